// ===== servo_host_model.sv
// Purpose: Host side of the parameter access port
// Assumes: Bank answers with the hand-over timing
// Notes: Released number and digit lines show inverted data, so stale values never pass
module servo_host_model (
  // Clock
  input wire logic clk_i,
  // Bank answers
  input wire logic acc_done_i,
  input wire logic acc_err_i,
  input wire logic rd_dig_valid_i,
  input wire logic [3:0] rd_dig_i,
  // Requests
  output logic acc_start_o,
  output logic acc_write_o,
  output logic [5:0] acc_num_o,
  output logic dig_valid_o,
  output logic [3:0] dig_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic done_seen;
  logic err_seen;
  logic [15:0] rd_word;
  initial begin
    {acc_start_o, acc_write_o, acc_num_o, dig_valid_o, dig_o} = '0;
    done_seen = 1'b0;
  end
  always @(posedge clk_i) begin
    if (acc_done_i) begin
      done_seen <= 1'b1;
      err_seen <= acc_err_i;
    end
    if (rd_dig_valid_i) rd_word <= {rd_word[11:0], rd_dig_i};
  end
  task automatic xfer(input logic w, input logic [5:0] n, input logic [15:0] v);
    int k;
    @(posedge clk_i);
    done_seen <= 1'b0;
    acc_start_o <= 1'b1;
    acc_write_o <= w;
    acc_num_o <= n;
    @(posedge clk_i);
    acc_start_o <= 1'b0;
    acc_num_o <= ~n;
    if (w) for (int i = 3; i >= 0; i--) begin
      dig_valid_o <= 1'b1;
      dig_o <= v[4*i+:4];
      @(posedge clk_i);
    end
    dig_valid_o <= 1'b0;
    dig_o <= ~dig_o;
    k = 0;
    while (!done_seen && k < 8) begin
      @(posedge clk_i);
      #1;
      k++;
    end
  endtask
endmodule

// ===== servo_option_parameter_bank.sv
// Purpose: Parameter bank 26 to 39 with option decode for a servo drive
// Assumes: All inputs synchronous to clk_i; digits arrive one per cycle
// Notes: Out of range writes are refused whole and leave the slot unchanged
`include "servo_option_parameter_bank_defs.svh"

module servo_option_parameter_bank
  import servo_option_parameter_bank_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Parameter access
  input wire logic acc_start_i,
  input wire logic acc_write_i,
  input wire logic [5:0] acc_num_i,
  input wire logic dig_valid_i,
  input wire logic [3:0] dig_i,
  output logic rd_dig_valid_o,
  output logic [3:0] rd_dig_o,
  output logic acc_done_o,
  output logic acc_err_o,
  output logic acc_busy_o,
  // Serial message handling
  input wire logic char_valid_i,
  input wire logic char_parity_err_i,
  input wire logic msg_done_i,
  input wire logic msg_ok_i,
  input wire logic msg_has_axis_i,
  output logic char_accept_o,
  output logic cmd_accept_o,
  output logic echo_reply_o,
  output logic ack_reply_o,
  output logic err_reply_o,
  // Drive signals
  input wire drive_outs_t outs_raw_i,
  input wire drive_ins_t ins_raw_i,
  input wire logic encoder_index_i,
  input wire logic external_clear_input_i,
  input wire logic manual_inch_move_i,
  output drive_outs_t outs_o,
  output logic decel_switch_input_o,
  output logic overtravel_input_o,
  output logic [7:0] cmd_vec_o,
  output logic origin_pulse_o,
  output logic ext_jog_o,
  output cfg_t cfg_o
);

  logic [15:0] bank_q [`PRM_COUNT];
  acc_state_t state_q;
  logic [3:0] slot_q;
  logic [1:0] dig_cnt_q;
  logic [15:0] shift_q;
  logic [15:0] o36;
  logic [15:0] o37;
  logic [15:0] o38;
  logic [15:0] o39;
  logic num_ok;
  logic [3:0] slot_d;
  logic [15:0] wr_word;
  logic den_m;
  logic fclr_m;
  logic [7:0] cmds_d;

  // Command code to one-hot command bit
  function automatic logic [7:0] cmd_bit(input logic [3:0] code);
    logic [7:0] v;
    v = 8'h00;
    if (code != CMD_NONE && code <= `CMD_CODE_MAX) begin
      v[3'(code - 4'h1)] = 1'b1;
    end
    return v;
  endfunction

  // Range check applied to a complete written word
  function automatic logic word_ok(input logic [3:0] slot, input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    case (slot)
      `SLOT_FWD_SWLIM, `SLOT_REV_SWLIM: begin
        ok = v[15] ? ((16'(~v) + 16'h0001) <= `SWLIM_MAG) : (v <= `SWLIM_MAG);
      end
      `SLOT_FWD_TRQ, `SLOT_REV_TRQ: ok = v <= `RST_TRQ_MAX;
      `SLOT_GEAR_NUM, `SLOT_GEAR_DEN: ok = v >= `GEAR_MIN && v <= `GEAR_MAX;
      `SLOT_ENC_PPR: ok = v >= `ENC_MIN && v <= `ENC_MAX;
      `SLOT_AXIS: ok = v <= `AXIS_MAX;
      `SLOT_OPT36: begin
        ok = !v[`O36_RSVD] && v[`O36_ABS_HI:`O36_ABS_LO] <= `ABS_CHK_MAX;
      end
      `SLOT_OPT37: begin
        ok = !v[`O37_RSVD] && v[`O37_SPIN_HI:`O37_SPIN_LO] <= `SPECIAL_IN_MAX;
      end
      `SLOT_OPT38: begin
        ok = v[15:12] <= `CMD_CODE_MAX && v[11:8] <= `CMD_CODE_MAX &&
             v[7:4] <= `CMD_CODE_MAX && v[3:0] <= `CMD_CODE_MAX;
      end
      `SLOT_OPT39: begin
        ok = v[`O39_RSVD_HI:`O39_RSVD_LO] == 3'h0 &&
             v[`O39_ORGM_HI:`O39_ORGM_LO] <= `ORG_METHOD_MAX &&
             v[`O39_FCLR_HI:`O39_FCLR_LO] <= `CMD_CODE_MAX;
      end
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction

  assign o36 = bank_q[`SLOT_OPT36];
  assign o37 = bank_q[`SLOT_OPT37];
  assign o38 = bank_q[`SLOT_OPT38];
  assign o39 = bank_q[`SLOT_OPT39];
  assign num_ok = acc_num_i >= `PRM_FIRST && acc_num_i <= `PRM_LAST;
  assign slot_d = 4'(acc_num_i - `PRM_FIRST);
  assign wr_word = {shift_q[11:0], dig_i};

  // Access sequencer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= S_IDLE;
      slot_q <= 4'h0;
      dig_cnt_q <= 2'h0;
      shift_q <= 16'h0000;
      acc_done_o <= 1'b0;
      acc_err_o <= 1'b0;
      acc_busy_o <= 1'b0;
      rd_dig_valid_o <= 1'b0;
      rd_dig_o <= 4'h0;
    end else begin
      acc_done_o <= 1'b0;
      acc_err_o <= 1'b0;
      rd_dig_valid_o <= 1'b0;
      case (state_q)
        S_IDLE: begin
          dig_cnt_q <= 2'h0;
          if (acc_start_i && !num_ok) begin
            acc_done_o <= 1'b1;
            acc_err_o <= 1'b1;
          end else if (acc_start_i && acc_write_i) begin
            state_q <= S_WR;
            slot_q <= slot_d;
            acc_busy_o <= 1'b1;
          end else if (acc_start_i) begin
            state_q <= S_RD;
            slot_q <= slot_d;
            shift_q <= bank_q[slot_d];
            acc_busy_o <= 1'b1;
          end
        end
        S_WR: begin
          if (dig_valid_i) begin
            shift_q <= wr_word;
            dig_cnt_q <= dig_cnt_q + 2'h1;
            if (dig_cnt_q == 2'h3) begin
              state_q <= S_IDLE;
              acc_busy_o <= 1'b0;
              acc_done_o <= 1'b1;
              acc_err_o <= !word_ok(slot_q, wr_word);
            end
          end
        end
        S_RD: begin
          rd_dig_valid_o <= 1'b1;
          rd_dig_o <= shift_q[15:12];
          shift_q <= {shift_q[11:0], 4'h0};
          dig_cnt_q <= dig_cnt_q + 2'h1;
          if (dig_cnt_q == 2'h3) begin
            state_q <= S_IDLE;
            acc_busy_o <= 1'b0;
            acc_done_o <= 1'b1;
          end
        end
        default: begin
          state_q <= S_IDLE;
          acc_busy_o <= 1'b0;
        end
      endcase
    end
  end

  // Bank storage, factory settings on reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bank_q[`SLOT_JOG1] <= `RST_JOG1;
      bank_q[`SLOT_JOG2] <= `RST_JOG2;
      bank_q[`SLOT_FWD_TRQ] <= `RST_TRQ_MAX;
      bank_q[`SLOT_REV_TRQ] <= `RST_TRQ_MAX;
      bank_q[`SLOT_FWD_SWLIM] <= `RST_SWLIM;
      bank_q[`SLOT_REV_SWLIM] <= `RST_SWLIM;
      bank_q[`SLOT_GEAR_NUM] <= `RST_GEAR;
      bank_q[`SLOT_GEAR_DEN] <= `RST_GEAR;
      bank_q[`SLOT_ENC_PPR] <= `RST_ENC_PPR;
      bank_q[`SLOT_AXIS] <= `RST_AXIS;
      bank_q[`SLOT_OPT36] <= `RST_OPT;
      bank_q[`SLOT_OPT37] <= `RST_OPT;
      bank_q[`SLOT_OPT38] <= `RST_OPT;
      bank_q[`SLOT_OPT39] <= `RST_OPT;
    end else if (state_q == S_WR && dig_valid_i && dig_cnt_q == 2'h3 &&
                 word_ok(slot_q, wr_word)) begin
      bank_q[slot_q] <= wr_word;
    end
  end

  // Decoded configuration
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o.start_from_current <= o36[`O36_START];
      cfg_o.mode_switch_sel <= o36[`O36_MODE_HI:`O36_MODE_LO];
      cfg_o.echo_text <= o36[`O36_ECHO];
      cfg_o.ack_reply_en <= o36[`O36_ACK];
      cfg_o.err_reply_en <= o36[`O36_ERR];
      cfg_o.ignore_no_axis <= o36[`O36_NOAXIS];
      cfg_o.abs_cycle_check <= o36[`O36_ABS_HI:`O36_ABS_LO];
      cfg_o.ref_from_pulse_train <= o36[`O36_PTRAIN];
      cfg_o.abs_encoder <= o36[`O36_ABSENC];
      cfg_o.alt_origin_method <= o36[`O36_ALTORG];
      cfg_o.origin_negative <= o36[`O36_ORGDIR];
      cfg_o.ext_jog_en <= o37[`O37_EXT_JOG];
      cfg_o.pdc_en <= o39[`O39_PDC_EN];
      cfg_o.pdc_multiplier <= o39[`O39_PDC_MULT];
      cfg_o.ref_buffered <= o39[`O39_BUFM];
      cfg_o.ref_overwrite <= o39[`O39_OVRW];
      cfg_o.origin_from_clear <= o39[`O39_ORG_XCLEAR];
      cfg_o.origin_method <= o39[`O39_ORGM_HI:`O39_ORGM_LO];
      cfg_o.ignore_parity <= o39[`O39_PARITY];
      cfg_o.gear_num <= bank_q[`SLOT_GEAR_NUM];
      cfg_o.gear_den <= bank_q[`SLOT_GEAR_DEN];
      cfg_o.enc_ppr <= bank_q[`SLOT_ENC_PPR];
      cfg_o.axis_num <= bank_q[`SLOT_AXIS];
    end
  end

  // Serial link answers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      char_accept_o <= 1'b0;
      cmd_accept_o <= 1'b0;
      echo_reply_o <= 1'b0;
      ack_reply_o <= 1'b0;
      err_reply_o <= 1'b0;
    end else begin
      char_accept_o <= char_valid_i && (o39[`O39_PARITY] || !char_parity_err_i);
      cmd_accept_o <= msg_done_i && (msg_has_axis_i || !o36[`O36_NOAXIS]);
      echo_reply_o <= msg_done_i && (msg_has_axis_i || !o36[`O36_NOAXIS]) &&
                      o36[`O36_ECHO];
      ack_reply_o <= msg_done_i && (msg_has_axis_i || !o36[`O36_NOAXIS]) &&
                     msg_ok_i && o36[`O36_ACK];
      err_reply_o <= msg_done_i && (msg_has_axis_i || !o36[`O36_NOAXIS]) &&
                     !msg_ok_i && o36[`O36_ERR];
    end
  end

  // Masked inputs feed the allocation too
  assign den_m = ins_raw_i.drive_enable && !o37[`O37_MSK_DEN];
  assign fclr_m = ins_raw_i.fault_clear && !o37[`O37_MSK_FCLR];

  // Command vector from inputs
  always_comb begin
    cmds_d = 8'h00;
    if (o37[`O37_SPIN_LO]) begin
      cmds_d = (cmd_bit(o38[15:12]) & {8{ins_raw_i.reverse_current_limit}}) |
               (cmd_bit(o38[11:8]) & {8{ins_raw_i.forward_current_limit}}) |
               (cmd_bit(o38[7:4]) & {8{ins_raw_i.proportional_control}}) |
               (cmd_bit(o38[3:0]) & {8{den_m}}) |
               (cmd_bit(o39[`O39_FCLR_HI:`O39_FCLR_LO]) & {8{fclr_m}});
    end else begin
      cmds_d = (cmd_bit(CMD_DRIVE_ENABLE) & {8{den_m}}) |
               (cmd_bit(CMD_PROP_CONTROL) & {8{ins_raw_i.proportional_control}}) |
               (cmd_bit(CMD_FAULT_CLEAR) & {8{fclr_m}});
    end
  end

  // Drive pin conditioning
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      outs_o <= '0;
      decel_switch_input_o <= 1'b0;
      overtravel_input_o <= 1'b0;
      cmd_vec_o <= 8'h00;
      origin_pulse_o <= 1'b0;
      ext_jog_o <= 1'b0;
    end else begin
      // inversion after masking, so a masked pin sits at its idle level
      outs_o.current_limit <= (outs_raw_i.current_limit && !o37[`O37_MSK_CLIM]) ^
                              o37[`O37_INV_CLIM];
      outs_o.positioning_done <= (outs_raw_i.positioning_done && !o37[`O37_MSK_PDONE]) ^
                                 o37[`O37_INV_PDONE];
      outs_o.brake <= (outs_raw_i.brake && !o37[`O37_MSK_BRK]) ^ o37[`O37_INV_BRK];
      outs_o.fault <= (outs_raw_i.fault && !o37[`O37_MSK_FLT]) ^ o37[`O37_INV_FLT];
      decel_switch_input_o <= ins_raw_i.decel_switch ^ o37[`O37_INV_DECEL];
      overtravel_input_o <= ins_raw_i.overtravel && !o37[`O37_MSK_OVTR];
      cmd_vec_o <= cmds_d;
      origin_pulse_o <= o39[`O39_ORG_XCLEAR] ? external_clear_input_i : encoder_index_i;
      ext_jog_o <= manual_inch_move_i && o37[`O37_EXT_JOG];
    end
  end

endmodule

// ===== servo_option_parameter_bank_chk.sv
// Purpose: Port-level checks for the parameter bank
// Assumes: Bound to every bank instance
// Notes: Replies are judged against cfg_o, which lags the bank as they do
module servo_option_parameter_bank_chk
  import servo_option_parameter_bank_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Access port
  input wire logic acc_start_i,
  input wire logic acc_write_i,
  input wire logic [5:0] acc_num_i,
  input wire logic acc_busy_o,
  input wire logic acc_done_o,
  input wire logic acc_err_o,
  input wire logic rd_dig_valid_o,
  // Link and drive
  input wire logic msg_done_i,
  input wire logic msg_ok_i,
  input wire logic msg_has_axis_i,
  input wire logic ack_reply_o,
  input wire logic err_reply_o,
  input wire logic cmd_accept_o,
  input wire logic encoder_index_i,
  input wire logic external_clear_input_i,
  input wire logic origin_pulse_o,
  input wire cfg_t cfg_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic take;
  logic num_ok;
  assign take = acc_start_i && !acc_busy_o;
  assign num_ok = acc_num_i >= 6'd26 && acc_num_i <= 6'd39;

  read_walk_a: assert property (
    take && !acc_write_i && num_ok |=> ##1 rd_dig_valid_o [*3] ##1
      (rd_dig_valid_o && acc_done_o && !acc_err_o))
    else $error("read did not return four digits");
  write_len_a: assert property (
    take && acc_write_i && num_ok |=> (acc_busy_o && !acc_done_o) [*4])
    else $error("write ended before four digits");
  gear_range_a: assert property (
    $past(rst_b_i) |-> cfg_o.gear_num inside {[16'h0001:16'h7530]} &&
      cfg_o.gear_den inside {[16'h0001:16'h7530]})
    else $error("gear constant out of range");
  ppr_range_a: assert property (
    $past(rst_b_i) |-> cfg_o.enc_ppr inside {[16'h0201:16'h8000]})
    else $error("encoder count out of range");
  code_range_a: assert property (
    cfg_o.origin_method <= 3'h6 && cfg_o.abs_cycle_check <= 4'h5)
    else $error("option code out of range");
  ack_reply_a: assert property (
    msg_done_i && msg_has_axis_i && msg_ok_i |=>
      ack_reply_o == cfg_o.ack_reply_en && !err_reply_o)
    else $error("acknowledge reply wrong");
  err_reply_a: assert property (
    msg_done_i && msg_has_axis_i && !msg_ok_i |=>
      err_reply_o == cfg_o.err_reply_en && !ack_reply_o)
    else $error("error reply wrong");
  no_axis_a: assert property (
    msg_done_i && !msg_has_axis_i |=> cmd_accept_o == !cfg_o.ignore_no_axis)
    else $error("axis-less command handling wrong");
  origin_sel_a: assert property (
    $past(rst_b_i) |-> origin_pulse_o == (cfg_o.origin_from_clear ?
      $past(external_clear_input_i) : $past(encoder_index_i)))
    else $error("origin pulse source wrong");
endmodule

bind servo_option_parameter_bank servo_option_parameter_bank_chk chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .acc_start_i(acc_start_i), .acc_write_i(acc_write_i),
  .acc_num_i(acc_num_i), .acc_busy_o(acc_busy_o), .acc_done_o(acc_done_o),
  .acc_err_o(acc_err_o), .rd_dig_valid_o(rd_dig_valid_o), .msg_done_i(msg_done_i),
  .msg_ok_i(msg_ok_i), .msg_has_axis_i(msg_has_axis_i), .ack_reply_o(ack_reply_o),
  .err_reply_o(err_reply_o), .cmd_accept_o(cmd_accept_o), .encoder_index_i(encoder_index_i),
  .external_clear_input_i(external_clear_input_i), .origin_pulse_o(origin_pulse_o),
  .cfg_o(cfg_o));

// ===== servo_option_parameter_bank_defs.svh
// Purpose: Offsets, field positions, limits and reset values of the parameter bank
// Assumes: Included by bare name
// Notes: Parameter numbers map onto bank slots by subtracting the first number
`ifndef SERVO_OPTION_PARAMETER_BANK_DEFS_SVH
`define SERVO_OPTION_PARAMETER_BANK_DEFS_SVH

// Parameter numbers and bank slots
`define PRM_FIRST 6'd26
`define PRM_LAST 6'd39
`define PRM_COUNT 14
`define SLOT_JOG1 4'd0
`define SLOT_JOG2 4'd1
`define SLOT_FWD_TRQ 4'd2
`define SLOT_REV_TRQ 4'd3
`define SLOT_FWD_SWLIM 4'd4
`define SLOT_REV_SWLIM 4'd5
`define SLOT_GEAR_NUM 4'd6
`define SLOT_GEAR_DEN 4'd7
`define SLOT_ENC_PPR 4'd8
`define SLOT_AXIS 4'd9
`define SLOT_OPT36 4'd10
`define SLOT_OPT37 4'd11
`define SLOT_OPT38 4'd12
`define SLOT_OPT39 4'd13

// Factory settings
`define RST_JOG1 16'h03e8
`define RST_JOG2 16'h00c8
`define RST_TRQ_MAX 16'h012c
`define RST_SWLIM 16'h0000
`define RST_GEAR 16'h0001
`define RST_ENC_PPR 16'h0800
`define RST_AXIS 16'h0063
`define RST_OPT 16'h0000

// Limits
`define GEAR_MIN 16'h0001
`define GEAR_MAX 16'h7530
`define ENC_MIN 16'h0201
`define ENC_MAX 16'h8000
`define AXIS_MAX 16'h0063
`define SWLIM_MAG 16'h7530
`define ABS_CHK_MAX 4'h5
`define ORG_METHOD_MAX 3'h6
`define CMD_CODE_MAX 4'h8
`define SPECIAL_IN_MAX 2'h1

// Option word 36 fields
`define O36_RSVD 15
`define O36_START 14
`define O36_MODE_HI 13
`define O36_MODE_LO 12
`define O36_ECHO 11
`define O36_ACK 10
`define O36_ERR 9
`define O36_NOAXIS 8
`define O36_ABS_HI 7
`define O36_ABS_LO 4
`define O36_PTRAIN 3
`define O36_ABSENC 2
`define O36_ALTORG 1
`define O36_ORGDIR 0

// Option word 37 fields
`define O37_INV_CLIM 15
`define O37_INV_PDONE 14
`define O37_INV_BRK 13
`define O37_INV_FLT 12
`define O37_MSK_CLIM 11
`define O37_MSK_PDONE 10
`define O37_MSK_BRK 9
`define O37_MSK_FLT 8
`define O37_SPIN_HI 7
`define O37_SPIN_LO 6
`define O37_RSVD 5
`define O37_INV_DECEL 4
`define O37_MSK_FCLR 3
`define O37_EXT_JOG 2
`define O37_MSK_OVTR 1
`define O37_MSK_DEN 0

// Option word 39 fields
`define O39_RSVD_HI 15
`define O39_RSVD_LO 13
`define O39_PARITY 12
`define O39_PDC_MULT 11
`define O39_PDC_EN 10
`define O39_BUFM 9
`define O39_OVRW 8
`define O39_ORG_XCLEAR 7
`define O39_ORGM_HI 6
`define O39_ORGM_LO 4
`define O39_FCLR_HI 3
`define O39_FCLR_LO 0

`endif

// ===== servo_option_parameter_bank_pkg.sv
// Purpose: Types shared by the parameter bank
// Assumes: Field positions live in the defs header
// Notes: Command codes index the command vector at code minus one
package servo_option_parameter_bank_pkg;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_WR = 3'b010,
    S_RD = 3'b100
  } acc_state_t;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_DRIVE_ENABLE = 4'h1,
    CMD_PROP_CONTROL = 4'h2,
    CMD_START = 4'h3,
    CMD_HOLD = 4'h4,
    CMD_REF_POINT = 4'h5,
    CMD_SKIP = 4'h6,
    CMD_ORIGIN_RETURN = 4'h7,
    CMD_FAULT_CLEAR = 4'h8
  } cmd_code_t;

  typedef struct packed {
    logic start_from_current;
    logic [1:0] mode_switch_sel;
    logic echo_text;
    logic ack_reply_en;
    logic err_reply_en;
    logic ignore_no_axis;
    logic [3:0] abs_cycle_check;
    logic ref_from_pulse_train;
    logic abs_encoder;
    logic alt_origin_method;
    logic origin_negative;
    logic ext_jog_en;
    logic pdc_en;
    logic pdc_multiplier;
    logic ref_buffered;
    logic ref_overwrite;
    logic origin_from_clear;
    logic [2:0] origin_method;
    logic ignore_parity;
    logic [15:0] gear_num;
    logic [15:0] gear_den;
    logic [15:0] enc_ppr;
    logic [15:0] axis_num;
  } cfg_t;

  typedef struct packed {
    logic current_limit;
    logic positioning_done;
    logic brake;
    logic fault;
  } drive_outs_t;

  typedef struct packed {
    logic decel_switch;
    logic fault_clear;
    logic overtravel;
    logic drive_enable;
    logic reverse_current_limit;
    logic forward_current_limit;
    logic proportional_control;
  } drive_ins_t;

endpackage

// ===== servo_option_parameter_bank_tb_top.sv
// Purpose: Self-checking bench for the parameter bank
// Assumes: Host model drives the access port, the bench the rest
// Notes: Outputs are read two edges after a change, msg and chr replies one edge after, past the register stage
`define CHK(a, b) begin \
  checks_done++; \
  if ((a) !== (b)) begin \
    num_errors++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); \
  end \
end
module servo_option_parameter_bank_tb_top
  import servo_option_parameter_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_b_i, acc_start, acc_write, dig_valid, rd_dig_valid, acc_done, acc_err;
  logic [5:0] acc_num;
  logic [3:0] dig, rd_dig;
  logic char_valid, char_perr, char_accept, msg_done, msg_ok, msg_axis, cmd_accept;
  logic echo, ack, err_rep, enc_idx, ext_clear, jog_in, origin, ext_jog, decel, ovtr;
  drive_outs_t outs_raw, outs;
  drive_ins_t ins_raw;
  logic [7:0] cmd_vec;
  cfg_t cfg;
  int num_errors, checks_done, cycles;
  logic [15:0] fac [26:39] = '{16'h03e8, 16'h00c8, 16'h012c, 16'h012c, 16'h0000,
    16'h0000, 16'h0001, 16'h0001, 16'h0800, 16'h0063, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [38:0] tab [13] = '{{6'd32, 16'h7530, 1'b0, 16'h7530},
    {6'd32, 16'h7531, 1'b1, 16'h7530}, {6'd33, 16'h0000, 1'b1, 16'h0001},
    {6'd34, 16'h0201, 1'b0, 16'h0201}, {6'd34, 16'h0200, 1'b1, 16'h0201},
    {6'd34, 16'h8000, 1'b0, 16'h8000}, {6'd34, 16'h8001, 1'b1, 16'h8000},
    {6'd36, 16'h0050, 1'b0, 16'h0050}, {6'd36, 16'h0060, 1'b1, 16'h0050},
    {6'd39, 16'h0060, 1'b0, 16'h0060}, {6'd39, 16'h0070, 1'b1, 16'h0060},
    {6'd37, 16'h0040, 1'b0, 16'h0040}, {6'd37, 16'h0080, 1'b1, 16'h0040}};

  servo_host_model host (.clk_i(clk_i), .acc_done_i(acc_done), .acc_err_i(acc_err),
    .rd_dig_valid_i(rd_dig_valid), .rd_dig_i(rd_dig), .acc_start_o(acc_start),
    .acc_write_o(acc_write), .acc_num_o(acc_num), .dig_valid_o(dig_valid), .dig_o(dig));
  servo_option_parameter_bank dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .acc_start_i(acc_start), .acc_write_i(acc_write), .acc_num_i(acc_num),
    .dig_valid_i(dig_valid), .dig_i(dig), .rd_dig_valid_o(rd_dig_valid), .rd_dig_o(rd_dig),
    .acc_done_o(acc_done), .acc_err_o(acc_err), .acc_busy_o(), .char_valid_i(char_valid),
    .char_parity_err_i(char_perr), .msg_done_i(msg_done), .msg_ok_i(msg_ok),
    .msg_has_axis_i(msg_axis), .char_accept_o(char_accept), .cmd_accept_o(cmd_accept),
    .echo_reply_o(echo), .ack_reply_o(ack), .err_reply_o(err_rep), .outs_raw_i(outs_raw),
    .ins_raw_i(ins_raw), .encoder_index_i(enc_idx), .external_clear_input_i(ext_clear),
    .manual_inch_move_i(jog_in), .outs_o(outs), .decel_switch_input_o(decel),
    .overtravel_input_o(ovtr), .cmd_vec_o(cmd_vec), .origin_pulse_o(origin),
    .ext_jog_o(ext_jog), .cfg_o(cfg));

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [5:0] n, input logic [15:0] v, input logic e);
    host.xfer(1'b1, n, v);
    `CHK(host.done_seen, 1'b1)
    `CHK(host.err_seen, e)
  endtask
  task automatic rd(input logic [5:0] n, input logic [15:0] x);
    host.xfer(1'b0, n, 16'h0000);
    `CHK(host.done_seen, 1'b1)
    `CHK(host.rd_word, x)
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic msg(input logic ok, input logic ax, input logic [3:0] x);
    @(posedge clk_i);
    {msg_done, msg_ok, msg_axis} <= {1'b1, ok, ax};
    @(posedge clk_i);
    msg_done <= 1'b0;
    #1;
    `CHK({cmd_accept, echo, ack, err_rep}, x)
  endtask
  task automatic chr(input logic pe, input logic x);
    @(posedge clk_i);
    {char_valid, char_perr} <= {1'b1, pe};
    @(posedge clk_i);
    char_valid <= 1'b0;
    #1;
    `CHK(char_accept, x)
  endtask
  task automatic pins(input logic [3:0] o, input logic [6:0] i, input logic [1:0] oc);
    @(posedge clk_i);
    outs_raw <= o;
    ins_raw <= i;
    {enc_idx, ext_clear} <= oc;
    settle();
  endtask

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Ceiling well above the roughly 520 cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    {rst_b_i, char_valid, char_perr, msg_done, msg_ok, msg_axis} = '0;
    {outs_raw, ins_raw, enc_idx, ext_clear, jog_in} = '0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    settle();
    `CHK(cfg.enc_ppr, 16'h0800)
    for (int n = 26; n <= 39; n++) rd(6'(n), fac[n]);
    foreach (tab[i]) begin
      wr(tab[i][38:33], tab[i][32:17], tab[i][16]);
      rd(tab[i][38:33], tab[i][15:0]);
    end
    wr(6'd40, 16'h0001, 1'b1);
    wr(6'd32, 16'h1234, 1'b0);
    settle();
    `CHK(cfg.gear_num, 16'h1234)
    for (int c = 0; c < 4; c++) begin
      wr(6'd36, {2'b01, 2'(c), 12'hf3b}, 1'b0);
      settle();
      `CHK(cfg[88:74], {1'b1, 2'(c), 12'hf3b})
    end
    msg(1'b1, 1'b1, 4'b1110);
    msg(1'b0, 1'b1, 4'b1101);
    msg(1'b1, 1'b0, 4'b0000);
    wr(6'd36, 16'h0000, 1'b0);
    settle();
    msg(1'b1, 1'b1, 4'b1000);
    msg(1'b0, 1'b0, 4'b1000);
    chr(1'b1, 1'b0);
    chr(1'b0, 1'b1);
    wr(6'd39, 16'h1b50, 1'b0);
    settle();
    `CHK(cfg[72:64], 9'h0eb)
    chr(1'b1, 1'b1);
    pins(4'h0, 7'h00, 2'b10);
    `CHK(origin, 1'b1)
    wr(6'd39, 16'h0080, 1'b0);
    settle();
    `CHK(origin, 1'b0)
    pins(4'h0, 7'h00, 2'b01);
    `CHK(origin, 1'b1)
    @(posedge clk_i);
    jog_in <= 1'b1;
    wr(6'd37, 16'ha614, 1'b0);
    pins(4'hf, 7'h70, 2'b00);
    `CHK({outs, decel, ovtr, ext_jog, cfg[73]}, 8'h37)
    pins(4'h0, 7'h50, 2'b00);
    `CHK({outs, decel, ovtr}, 6'h29)
    wr(6'd37, 16'h0003, 1'b0);
    settle();
    `CHK({outs, ovtr, ext_jog}, 6'h00)
    wr(6'd37, 16'h0000, 1'b0);
    pins(4'h0, 7'h29, 2'b00);
    `CHK(cmd_vec, 8'h83)
    wr(6'd37, 16'h0009, 1'b0);
    settle();
    `CHK(cmd_vec, 8'h02)
    wr(6'd37, 16'h0040, 1'b0);
    pins(4'h0, 7'h04, 2'b00);
    for (int c = 0; c <= 8; c++) begin
      wr(6'd38, {4'(c), 12'h000}, 1'b0);
      settle();
      `CHK(cmd_vec, 8'(c ? 1 << (c - 1) : 0))
    end
    stop_test();
  end
endmodule
